// [core/cib_pkg.sv]
package cib_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CMP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK_SRC = 8'h04;
  localparam logic [7:0] ADDR_MASK_GATE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // ---------------------------------------------------------------
  // reset values and writable bits
  // ---------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] SRC_RESET = 16'h0000;
  localparam logic [15:0] GATE_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h0013;
  localparam logic [15:0] SRC_WMASK = 16'h0fff;
  localparam logic [15:0] GATE_WMASK = 16'hbfff;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int REF_SEL_BIT = 4;
  localparam int CHAN_LSB = 0;
  localparam int SRC_C_LSB = 8;
  localparam int SRC_B_LSB = 4;
  localparam int SRC_A_LSB = 0;
  localparam int MASK_A = 0;
  localparam int MASK_B = 1;
  localparam int MASK_C = 2;

  // ---------------------------------------------------------------
  // mask source codes, 0110..1111 reserved
  // ---------------------------------------------------------------
  localparam logic [3:0] SRC_LAST_VALID = 4'h5;
  localparam int PWM_OUTS = 6;

  typedef enum logic [1:0] {
    CIB_NEG_PIN_B = 2'h0,
    CIB_NEG_PIN_C = 2'h1,
    CIB_NEG_PIN_D = 2'h2,
    CIB_NEG_BANDGAP = 2'h3
  } cib_neg_chan_t;

  // pwm generator outputs, pair1 low in bit 0
  typedef struct packed {
    logic pwmPair3High;
    logic pwmPair3Low;
    logic pwmPair2High;
    logic pwmPair2Low;
    logic pwmPair1High;
    logic pwmPair1Low;
  } cib_pwm_t;

  // mask gating control layout
  typedef struct packed {
    logic maskLevelSelect;
    logic unused14;
    logic orCTrueEnable;
    logic orCInvertedEnable;
    logic orBTrueEnable;
    logic orBInvertedEnable;
    logic orATrueEnable;
    logic orAInvertedEnable;
    logic andOutInvertedToOr;
    logic andOutTrueToOr;
    logic andCTrueEnable;
    logic andCInvertedEnable;
    logic andBTrueEnable;
    logic andBInvertedEnable;
    logic andATrueEnable;
    logic andAInvertedEnable;
  } cib_gate_t;

endpackage : cib_pkg

// [core/cib_mask_mux.sv]
`timescale 1ns/1ps
module cib_mask_mux (
  input wire cib_pkg::cib_pwm_t pwm,
  input wire logic [3:0] sourceCode,
  output logic maskSignal
);

  // ---------------------------------------------------------------
  // source decode
  // ---------------------------------------------------------------
  // reserved codes give a quiet low mask rather than an unknown
  wire logic codeValid = (sourceCode <= cib_pkg::SRC_LAST_VALID);
  wire logic [5:0] pwmBits = pwm;
  wire logic [2:0] pick = sourceCode[2:0];

  assign maskSignal = codeValid & pwmBits[pick];

endmodule : cib_mask_mux

// [core/cib_top.sv]
`timescale 1ns/1ps
module cib_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cib_pkg::cib_pwm_t pwm,
  input wire logic compRaw,
  output logic positiveInputRefSelect,
  output cib_pkg::cib_neg_chan_t negativeInputChannel,
  output logic [2:0] maskSignals,
  output logic blankMask,
  output logic compGated
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] maskSrc_q;
  logic [15:0] maskGate_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;
  logic [2:0] maskSig_q;
  logic blank_q;
  logic compGated_q;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // no wait state: pready is set by the setup cycle so it is a flop
  wire logic setupPhase = psel & ~penable;
  wire logic accessDone = psel & penable & pready_q;
  wire logic hitCtrl = (paddr == cib_pkg::ADDR_CMP_CTRL);
  wire logic hitSrc = (paddr == cib_pkg::ADDR_MASK_SRC);
  wire logic hitGate = (paddr == cib_pkg::ADDR_MASK_GATE);
  wire logic hitStat = (paddr == cib_pkg::ADDR_STATUS);
  wire logic hitAny = hitCtrl | hitSrc | hitGate | hitStat;
  wire logic wrCtrl = accessDone & pwrite & hitCtrl;
  wire logic wrSrc = accessDone & pwrite & hitSrc;
  wire logic wrGate = accessDone & pwrite & hitGate;

  // status is read only; a write there is refused with an error
  assign pslverr_d = setupPhase & (~hitAny | (pwrite & hitStat));

  wire logic [15:0] statusWord = {11'h000, compGated_q, blank_q, maskSig_q};

  assign prdata_d = !(setupPhase & ~pwrite) ? 32'h00000000 :
                    hitCtrl ? {16'h0000, ctrl_q} :
                    hitSrc ? {16'h0000, maskSrc_q} :
                    hitGate ? {16'h0000, maskGate_q} :
                    hitStat ? {16'h0000, statusWord} : 32'h00000000;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [15:0] wmask);
    merge = (old & ~wmask) | (wd[15:0] & wmask);
  endfunction : merge

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setupPhase;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= cib_pkg::CTRL_RESET;
      maskSrc_q <= cib_pkg::SRC_RESET;
      maskGate_q <= cib_pkg::GATE_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= merge(ctrl_q, pwdata, cib_pkg::CTRL_WMASK);
      end
      if (wrSrc) begin
        maskSrc_q <= merge(maskSrc_q, pwdata, cib_pkg::SRC_WMASK);
      end
      if (wrGate) begin
        maskGate_q <= merge(maskGate_q, pwdata, cib_pkg::GATE_WMASK);
      end
    end
  end

  // ---------------------------------------------------------------
  // input routing
  // ---------------------------------------------------------------
  assign positiveInputRefSelect = ctrl_q[cib_pkg::REF_SEL_BIT];
  assign negativeInputChannel = cib_pkg::cib_neg_chan_t'(ctrl_q[cib_pkg::CHAN_LSB +: 2]);

  // ---------------------------------------------------------------
  // mask source selection
  // ---------------------------------------------------------------
  logic maskANow;
  logic maskBNow;
  logic maskCNow;

  cib_mask_mux uMuxC (
    .pwm(pwm),
    .sourceCode(maskSrc_q[cib_pkg::SRC_C_LSB +: 4]),
    .maskSignal(maskCNow)
  );

  cib_mask_mux uMuxB (
    .pwm(pwm),
    .sourceCode(maskSrc_q[cib_pkg::SRC_B_LSB +: 4]),
    .maskSignal(maskBNow)
  );

  cib_mask_mux uMuxA (
    .pwm(pwm),
    .sourceCode(maskSrc_q[cib_pkg::SRC_A_LSB +: 4]),
    .maskSignal(maskANow)
  );

  // ---------------------------------------------------------------
  // gating network
  // ---------------------------------------------------------------
  function automatic logic term(input logic en, input logic sig);
    term = en & sig;
  endfunction : term

  wire cib_pkg::cib_gate_t gate = cib_pkg::cib_gate_t'(maskGate_q);

  // enables and the levels they would pass, C first
  wire logic [5:0] andEnables = {gate.andCTrueEnable, gate.andCInvertedEnable,
                                 gate.andBTrueEnable, gate.andBInvertedEnable,
                                 gate.andATrueEnable, gate.andAInvertedEnable};
  wire logic [5:0] andLevels = {maskCNow, ~maskCNow, maskBNow, ~maskBNow,
                                maskANow, ~maskANow};
  // unconnected inputs count as ones; with none connected the gate is low
  wire logic andOut = (|andEnables) & (&(andLevels | ~andEnables));

  wire logic orOut = term(gate.orCTrueEnable, maskCNow)
                   | term(gate.orCInvertedEnable, ~maskCNow)
                   | term(gate.orBTrueEnable, maskBNow)
                   | term(gate.orBInvertedEnable, ~maskBNow)
                   | term(gate.orATrueEnable, maskANow)
                   | term(gate.orAInvertedEnable, ~maskANow)
                   | term(gate.andOutInvertedToOr, ~andOut)
                   | term(gate.andOutTrueToOr, andOut);

  // level select 0: high mask blocks, so the reset state never blanks
  wire logic blocked = gate.maskLevelSelect ? ~orOut : orOut;
  wire logic gatedNow = compRaw & ~blocked;

  always_ff @(posedge mclk) begin
    if (rst) begin
      maskSig_q <= 3'h0;
      blank_q <= 1'b0;
      compGated_q <= 1'b0;
    end else begin
      maskSig_q <= {maskCNow, maskBNow, maskANow};
      blank_q <= orOut;
      compGated_q <= gatedNow;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign maskSignals = maskSig_q;
  assign blankMask = blank_q;
  assign compGated = compGated_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // independent reference for a mask source mux
  function automatic logic refMux(input logic [5:0] p, input logic [3:0] c);
    logic r;
    r = 1'b0;
    case (c)
      4'h0: r = p[0];
      4'h1: r = p[1];
      4'h2: r = p[2];
      4'h3: r = p[3];
      4'h4: r = p[4];
      4'h5: r = p[5];
      default: r = 1'b0;
    endcase
    refMux = r;
  endfunction : refMux

  wire logic [5:0] pwmFlat = pwm;

  property p_ref_select;
    wrCtrl |=> (positiveInputRefSelect == $past(pwdata[4]));
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("ref select not taken");

  property p_neg_channel;
    wrCtrl |=> (negativeInputChannel == $past(pwdata[1:0])) [*2] or wrCtrl;
  endproperty
  a_neg_channel: assert property (p_neg_channel) else $error("channel not taken");

  property p_mask_c;
    ##1 maskSig_q[cib_pkg::MASK_C] == $past(refMux(pwmFlat, maskSrc_q[11:8]));
  endproperty
  a_mask_c: assert property (p_mask_c) else $error("mask c source wrong");

  property p_mask_b;
    ##1 maskSig_q[cib_pkg::MASK_B] == $past(refMux(pwmFlat, maskSrc_q[7:4]));
  endproperty
  a_mask_b: assert property (p_mask_b) else $error("mask b source wrong");

  property p_mask_a;
    (maskSrc_q[3:0] > 4'h5) |=> !maskSig_q[cib_pkg::MASK_A];
  endproperty
  a_mask_a: assert property (p_mask_a) else $error("reserved a code not low");

  property p_level;
    ##1 compGated_q == ($past(compRaw) &&
                        ($past(maskGate_q[15]) ? blank_q : !blank_q));
  endproperty
  a_level: assert property (p_level) else $error("blanking level wrong");

  property p_or_a;
    (maskGate_q == 16'h0200) |=> (blank_q == maskSig_q[cib_pkg::MASK_A]);
  endproperty
  a_or_a: assert property (p_or_a) else $error("or a term wrong");

  property p_and_c;
    (maskGate_q == 16'h0050) |=> (blank_q == !maskSig_q[cib_pkg::MASK_C]);
  endproperty
  a_and_c: assert property (p_and_c) else $error("and inverted c wrong");

  property p_nand_only;
    (maskGate_q == 16'h0080) |=> blank_q;
  endproperty
  a_nand_only: assert property (p_nand_only) else $error("inverted and path wrong");

  property p_pand_empty;
    (maskGate_q == 16'h0040) |=> !blank_q;
  endproperty
  a_pand_empty: assert property (p_pand_empty) else $error("true and path wrong");

  property p_and_b;
    (maskGate_q == 16'h0048) |=> (blank_q == maskSig_q[cib_pkg::MASK_B]);
  endproperty
  a_and_b: assert property (p_and_b) else $error("and b term wrong");

  property p_idle_pass;
    (maskGate_q == 16'h0000) |=> (!blank_q && (compGated_q == $past(compRaw)));
  endproperty
  a_idle_pass: assert property (p_idle_pass) else $error("idle gating blanks");

  property p_apb_ready;
    (psel && !penable) |=> pready_q;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");

  property p_mask_c_reserved;
    (maskSrc_q[11:8] > 4'h5) |=> !maskSig_q[cib_pkg::MASK_C];
  endproperty
  a_mask_c_reserved: assert property (p_mask_c_reserved) else $error("reserved c code not low");

  property p_mask_b_reserved;
    (maskSrc_q[7:4] > 4'h5) |=> !maskSig_q[cib_pkg::MASK_B];
  endproperty
  a_mask_b_reserved: assert property (p_mask_b_reserved) else $error("reserved b code not low");

  property p_mask_a_src;
    ##1 maskSig_q[cib_pkg::MASK_A] == $past(refMux(pwmFlat, maskSrc_q[3:0]));
  endproperty
  a_mask_a_src: assert property (p_mask_a_src) else $error("mask a source wrong");

  property p_or_c_inv;
    (maskGate_q == 16'h1000) |=> (blank_q == !maskSig_q[cib_pkg::MASK_C]);
  endproperty
  a_or_c_inv: assert property (p_or_c_inv) else $error("or inverted c term wrong");

  property p_or_b_true;
    (maskGate_q == 16'h0800) |=> (blank_q == maskSig_q[cib_pkg::MASK_B]);
  endproperty
  a_or_b_true: assert property (p_or_b_true) else $error("or b term wrong");

  property p_and_c_true;
    (maskGate_q == 16'h0060) |=> (blank_q == maskSig_q[cib_pkg::MASK_C]);
  endproperty
  a_and_c_true: assert property (p_and_c_true) else $error("and true c wrong");

  property p_and_a_inv;
    (maskGate_q == 16'h0041) |=> (blank_q == !maskSig_q[cib_pkg::MASK_A]);
  endproperty
  a_and_a_inv: assert property (p_and_a_inv) else $error("and inverted a wrong");

  property p_and_conflict;
    (maskGate_q[13:0] == 14'h007f) |=> !blank_q;
  endproperty
  a_and_conflict: assert property (p_and_conflict) else $error("and conflict not low");

  property p_low_level;
    (maskGate_q == 16'h8080) |=> (blank_q && (compGated_q == $past(compRaw)));
  endproperty
  a_low_level: assert property (p_low_level) else $error("low level select wrong");

  property p_src_write;
    wrSrc |=> (maskSrc_q == ($past(pwdata[15:0]) & cib_pkg::SRC_WMASK));
  endproperty
  a_src_write: assert property (p_src_write) else $error("source write lost");

  property p_gate_write;
    wrGate |=> (maskGate_q == ($past(pwdata[15:0]) & cib_pkg::GATE_WMASK));
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gating write lost");

  property p_stat_refused;
    (accessDone && pwrite && hitStat) |-> pslverr_q;
  endproperty
  a_stat_refused: assert property (p_stat_refused) else $error("status write not refused");

  property p_upper_zero;
    pready_q |-> (prdata_q[31:16] == 16'h0000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");

  c_write_gate: cover property (wrGate);
  c_blanked: cover property (compRaw ##1 !compGated_q);
  c_read_status: cover property (accessDone && !pwrite && hitStat);
  c_bad_addr: cover property (pslverr_q && pready_q);
  c_low_level: cover property (maskGate_q[15] && compGated_q);

endmodule : cib_top

// [bench/cib_pwm_model.sv]
`timescale 1ns/1ps
module cib_pwm_model (
  input wire logic mclk,
  input wire logic rst,
  input wire cib_pkg::cib_pwm_t pwmReq,
  input wire logic compReq,
  output cib_pkg::cib_pwm_t pwm,
  output logic compRaw
);
  // ---------------------------------------------------------------
  // pwm generator and comparator core, both clocked by mclk
  // ---------------------------------------------------------------
  cib_pkg::cib_pwm_t pwmQ = '0;
  logic compQ = 1'b0;
  assign pwm = pwmQ;
  assign compRaw = compQ;
  // outputs held low in reset, like the real generator after power-on
  always @(posedge mclk) begin
    pwmQ <= rst ? '0 : pwmReq;
    compQ <= rst ? 1'b0 : compReq;
  end
endmodule : cib_pwm_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cib_pkg::cib_pwm_t pwmReq = '0;
  logic compReq = 1'b0;
  cib_pkg::cib_pwm_t pwm;
  logic compRaw;
  logic positiveInputRefSelect;
  cib_pkg::cib_neg_chan_t negativeInputChannel;
  logic [2:0] maskSignals;
  logic blankMask;
  logic compGated;
  int fails = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic er;

  always #20 mclk = ~mclk;

  cib_pwm_model i_cib_pwm_model (.mclk(mclk), .rst(rst), .pwmReq(pwmReq), .compReq(compReq),
    .pwm(pwm), .compRaw(compRaw));
  cib_top i_cib_top (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm(pwm), .compRaw(compRaw), .positiveInputRefSelect(positiveInputRefSelect),
    .negativeInputChannel(negativeInputChannel), .maskSignals(maskSignals),
    .blankMask(blankMask), .compGated(compGated));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // master holds the request until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0);
  endtask : apb

  // model adds one cycle, design one more; extra edge for margin
  task drive(input logic [5:0] p, input logic c);
    @(posedge mclk);
    pwmReq <= cib_pkg::cib_pwm_t'(p);
    compReq <= c;
    repeat (3) @(posedge mclk);
    #1;
  endtask : drive

  function automatic logic exp_blank(input logic [15:0] g, input logic [2:0] m);
    logic an;
    an = (|g[5:0]) & (~g[5] | m[2]) & (~g[4] | ~m[2]) & (~g[3] | m[1]) & (~g[2] | ~m[1])
      & (~g[1] | m[0]) & (~g[0] | ~m[0]);
    return (g[13] & m[2]) | (g[12] & ~m[2]) | (g[11] & m[1]) | (g[10] & ~m[1])
      | (g[9] & m[0]) | (g[8] & ~m[0]) | (g[7] & ~an) | (g[6] & an);
  endfunction : exp_blank

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task test_reset;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    $display("test_reset done");
  endtask : test_reset

  task test_ctrl;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, cib_pkg::ADDR_CMP_CTRL, 32'((i / 4) * 16 + i % 4));
      #1;
      chk(32'(positiveInputRefSelect), 32'(i / 4));
      chk(32'(negativeInputChannel), 32'(i % 4));
    end
    $display("test_ctrl done");
  endtask : test_ctrl

  task test_src;
    logic [5:0] p;
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 16; c++) begin
        apb(1'b1, cib_pkg::ADDR_MASK_SRC, 32'(c) << (4 * f));
        p = (c < 6) ? 6'(1 << c) : 6'h3f;
        drive(p, 1'b0);
        chk(32'(maskSignals[f]), 32'(c < 6));
        drive(~p, 1'b0);
        chk(32'(maskSignals[f]), 32'h0);
      end
    end
    $display("test_src done");
  endtask : test_src

  // masks: c = pair2 low, b = pair1 high, a = pair1 low
  task test_gate;
    logic [15:0] g;
    logic e;
    logic q;
    apb(1'b1, cib_pkg::ADDR_MASK_SRC, 32'h0210);
    for (int ps = 0; ps < 2; ps++) begin
      for (int i = 0; i < 16; i++) begin
        g = (i < 14) ? 16'(1 << i) : ((i == 14) ? 16'h0028 : 16'h003f);
        if (i < 6 || i > 13) g = g | (ps ? 16'h0080 : 16'h0040);
        if (ps) g = g | 16'h8000;
        apb(1'b1, cib_pkg::ADDR_MASK_GATE, 32'(g));
        for (int m = 0; m < 16; m++) begin
          drive(6'(m % 8), 1'(m / 8));
          e = exp_blank(g, 3'(m % 8));
          q = 1'(m / 8) & (g[15] ? e : ~e);
          chk(32'(blankMask), 32'(e));
          chk(32'(compGated), 32'(q));
          apb(1'b0, cib_pkg::ADDR_STATUS, 32'h0);
          chk(rd, {27'h0, q, e, 3'(m % 8)});
        end
      end
    end
    $display("test_gate done");
  endtask : test_gate

  // writable bits, read-only status and an unmapped address
  task test_refuse;
    logic [15:0] wm [3];
    wm = '{cib_pkg::CTRL_WMASK, cib_pkg::SRC_WMASK, cib_pkg::GATE_WMASK};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'(i * 4), 32'hffffffff);
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, {16'h0, wm[i]});
      apb(1'b1, 8'(i * 4), 32'h0);
    end
    apb(1'b1, cib_pkg::ADDR_STATUS, 32'hffffffff);
    chk(32'(er), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("test_refuse done");
  endtask : test_refuse

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    test_reset;
    test_ctrl;
    test_src;
    test_gate;
    test_refuse;
    report_and_stop;
  end

  // run needs about 4.3k cycles; generous margin before giving up
  initial begin
    #(40 * 60000);
    fails++;
    report_and_stop;
  end
endmodule : tb_top
